/* File: ssc_regs.svh */
// register offsets, field positions, answer values and codes for the status command block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
`define SSC_OFF_CMD 12'h000
`define SSC_OFF_ARG 12'h004
`define SSC_OFF_RESP 12'h008
`define SSC_OFF_STB 12'h00C
`define SSC_OFF_ERRPUSH 12'h010
`define SSC_OFF_IDN 12'h014
`define SSC_OFF_EVSET 12'h018
`define SSC_OFF_FLAGS 12'h01C
`define SSC_STB_QUES_BIT 3
`define SSC_STB_ESB_BIT 5
`define SSC_STB_RQS_BIT 6
`define SSC_QUES_OUT_BIT 10
`define SSC_QUES_IN_BIT 9
`define SSC_OPC_ANSWER 32'h00000001
`define SSC_TST_ANSWER 32'h00000000
`define SSC_ZERO_ANSWER 32'h00000000
`define SSC_ERR_EMPTY 32'h00000000
`define SSC_CMD_CLS 5'h01
`define SSC_CMD_ESE 5'h02
`define SSC_CMD_ESE_Q 5'h03
`define SSC_CMD_ESR_Q 5'h04
`define SSC_CMD_IDN_Q 5'h05
`define SSC_CMD_OPC 5'h06
`define SSC_CMD_OPC_Q 5'h07
`define SSC_CMD_RST 5'h08
`define SSC_CMD_SRE 5'h09
`define SSC_CMD_SRE_Q 5'h0A
`define SSC_CMD_STB_Q 5'h0B
`define SSC_CMD_TST_Q 5'h0C
`define SSC_CMD_WAI 5'h0D
`define SSC_CMD_INP_Q 5'h0E
`define SSC_CMD_OUT_Q 5'h0F
`define SSC_CMD_OPCOND_Q 5'h10
`define SSC_CMD_OPEN 5'h11
`define SSC_CMD_OPEN_Q 5'h12
`define SSC_CMD_OPEV_Q 5'h13
`define SSC_CMD_PRESET 5'h14
`define SSC_CMD_QCOND_Q 5'h15
`define SSC_CMD_QEN 5'h16
`define SSC_CMD_QEN_Q 5'h17
`define SSC_CMD_QEV_Q 5'h18
`define SSC_CMD_ERR_Q 5'h19
`define SSC_CMD_VER_Q 5'h1A
`endif

/* File: ssc_pkg.sv */
// types for the status command block
package ssc_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ssc_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ssc_apb_rsp_t;
	typedef struct packed {
		logic [15:0] code;
		logic [15:0] text_idx;
	} ssc_err_t;
endpackage : ssc_pkg

/* File: ssc_status_core.sv */
// status reporting and common command interpreter behind an apb slave
//
// Contract
// (R1) clear-status empties event registers, error queue
// (R2) event enable mask summarises into stb bit5
// (R3) event enable query returns held mask
// (R4) event register query returns then clears
// (R5) identification query returns module id text
// (R6) opc query answers one; opc, wai ignored
// (R7) self-test query always answers zero
// (R8) reset command clears on-board interrupt bit
// (R9) service enable mask drives stb bit6, request
// (R10) service enable query returns stored mask
// (R11) status byte query returns status byte
// (R12) input query: 0 signal, 1 none
// (R13) output query reports six detect circuits
// (R14) operation condition query returns that register
// (R15) operation enable write and read back
// (R16) operation event query returns event register
// (R17) preset zeroes operation and questionable enables
// (R18) questionable condition query returns live value
// (R19) questionable enable command stores mask
// (R20) questionable enable query returns it unchanged
// (R21) error query returns oldest error entry
// (R22) version query returns standard version number
// (R23) ques bit10 outputs missing, bit9 input
// (R24) enabled questionable events drive stb bit3
// (R25) output weights 1..32, sum without channel
// (R26) operation condition and event read zero
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_status_core #(
	parameter int ERR_DEPTH = 8,
	parameter logic [31:0] IDN_WORD = 32'h5A5A0001,
	parameter logic [31:0] VERSION_WORD = 32'h000007C7
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// apb slave
	input wire ssc_pkg::ssc_apb_req_t apb_req,
	output ssc_pkg::ssc_apb_rsp_t apb_rsp,
	// detect circuits, high means signal present
	input wire logic in_detect,
	input wire logic [5:0] out_detect,
	// service request and on-board interrupt
	output logic srq,
	output logic irq_bit
);
	import ssc_pkg::*;

	localparam int PW = $clog2(ERR_DEPTH);

	initial
	begin
		if (ERR_DEPTH < 2 || (1 << PW) != ERR_DEPTH)
			$error("ERR_DEPTH must be a power of two, at least 2");
	end

	function automatic logic [11:0] off_hit(input logic [11:0] a);
		off_hit = a & 12'hFFC;
	endfunction : off_hit

	// two-stage synchronisers for pins
	logic in_s1_reg, in_s2_reg;
	logic [5:0] out_s1_reg, out_s2_reg;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			in_s1_reg <= 1'b1;
			in_s2_reg <= 1'b1;
			out_s1_reg <= 6'h3F;
			out_s2_reg <= 6'h3F;
		end
		else
		begin
			in_s1_reg <= in_detect;
			in_s2_reg <= in_s1_reg;
			out_s1_reg <= out_detect;
			out_s2_reg <= out_s1_reg;
		end
	end

	logic [15:0] ques_cond;
	logic [5:0] out_fail;
	always_comb
	begin
		out_fail = ~out_s2_reg; // [R25]
		ques_cond = 16'h0000; // [R23]
		ques_cond[`SSC_QUES_OUT_BIT] = |out_fail; // [R23]
		ques_cond[`SSC_QUES_IN_BIT] = ~in_s2_reg; // [R23]
	end

	// state
	logic [7:0] ese_reg, ese_next;
	logic [7:0] esr_reg, esr_next;
	logic [7:0] sre_reg, sre_next;
	logic [15:0] qen_reg, qen_next;
	logic [15:0] qev_reg, qev_next;
	logic [15:0] ques_prev_reg, ques_prev_next;
	logic [15:0] open_reg, open_next;
	logic irq_reg, irq_next;
	logic [31:0] resp_reg, resp_next;
	logic ready_reg, ready_next;
	logic err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;
	logic srq_reg, srq_next;
	ssc_err_t err_mem_reg [ERR_DEPTH];
	ssc_err_t err_mem_next [ERR_DEPTH];
	logic [PW:0] wp_reg, wp_next, rp_reg, rp_next;

	logic [7:0] stb;
	logic acc, wr, rd;
	logic [11:0] a;
	logic [4:0] cmd;
	logic [31:0] arg;
	// command argument sits above the command code
	logic [23:0] carg;
	logic err_empty, err_full;
	always_comb
	begin
		stb = 8'h00;
		stb[`SSC_STB_QUES_BIT] = |(qev_reg & qen_reg); // [R24]
		stb[`SSC_STB_ESB_BIT] = |(esr_reg & ese_reg); // [R2]
		stb[`SSC_STB_RQS_BIT] = |(stb & sre_reg & 8'hBF); // [R9]
	end

	always_comb
	begin
		acc = apb_req.psel && apb_req.penable && !ready_reg;
		wr = acc && apb_req.pwrite;
		rd = acc && !apb_req.pwrite;
		a = off_hit(apb_req.paddr);
		cmd = apb_req.pwdata[4:0];
		arg = apb_req.pwdata;
		carg = apb_req.pwdata[31:8];
		err_empty = (wp_reg == rp_reg);
		err_full = (wp_reg[PW] != rp_reg[PW]) && (wp_reg[PW-1:0] == rp_reg[PW-1:0]);
		ese_next = ese_reg;
		esr_next = esr_reg;
		sre_next = sre_reg;
		qen_next = qen_reg;
		open_next = open_reg;
		irq_next = irq_reg;
		resp_next = resp_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		err_mem_next = err_mem_reg;
		ready_next = acc;
		err_next = 1'b0;
		rdata_next = 32'h00000000;
		ques_prev_next = ques_cond;
		// rising questionable conditions latch as events
		qev_next = qev_reg | (ques_cond & ~ques_prev_reg);
		if (wr && a == `SSC_OFF_CMD)
		begin
			case (cmd)
				`SSC_CMD_CLS:
				begin
					esr_next = 8'h00; // [R1]
					qev_next = ques_cond & ~ques_prev_reg; // [R1]
					rp_next = wp_reg; // [R1]
				end
				`SSC_CMD_ESE: ese_next = carg[7:0]; // [R2]
				`SSC_CMD_ESE_Q: resp_next = {24'h000000, ese_reg}; // [R3]
				`SSC_CMD_ESR_Q:
				begin
					resp_next = {24'h000000, esr_reg}; // [R4]
					esr_next = 8'h00; // [R4]
				end
				`SSC_CMD_IDN_Q: resp_next = IDN_WORD; // [R5]
				`SSC_CMD_OPC_Q: resp_next = `SSC_OPC_ANSWER; // [R6]
				`SSC_CMD_OPC, `SSC_CMD_WAI: resp_next = resp_reg; // [R6]
				`SSC_CMD_RST: irq_next = 1'b0; // [R8]
				`SSC_CMD_SRE: sre_next = carg[7:0] & 8'hBF; // [R9]
				`SSC_CMD_SRE_Q: resp_next = {24'h000000, sre_reg}; // [R10]
				`SSC_CMD_STB_Q: resp_next = {24'h000000, stb}; // [R11]
				`SSC_CMD_TST_Q: resp_next = `SSC_TST_ANSWER; // [R7]
				`SSC_CMD_INP_Q: resp_next = {31'h00000000, ~in_s2_reg}; // [R12]
				`SSC_CMD_OUT_Q:
				begin
					if (carg[2:0] >= 3'd1 && carg[2:0] <= 3'd6)
						resp_next = {31'h00000000, out_fail[carg[2:0] - 3'd1]}; // [R13]
					else
						resp_next = {26'h0000000, out_fail}; // [R25]
				end
				`SSC_CMD_OPCOND_Q, `SSC_CMD_OPEV_Q: resp_next = `SSC_ZERO_ANSWER; // [R14] [R16] [R26]
				`SSC_CMD_OPEN: open_next = carg[15:0]; // [R15]
				`SSC_CMD_OPEN_Q: resp_next = {16'h0000, open_reg}; // [R15]
				`SSC_CMD_PRESET:
				begin
					open_next = 16'h0000; // [R17]
					qen_next = 16'h0000; // [R17]
				end
				`SSC_CMD_QCOND_Q: resp_next = {16'h0000, ques_cond}; // [R18]
				`SSC_CMD_QEN: qen_next = {1'b0, carg[14:0]}; // [R19]
				`SSC_CMD_QEN_Q: resp_next = {16'h0000, qen_reg}; // [R19] [R20]
				`SSC_CMD_QEV_Q:
				begin
					resp_next = {16'h0000, qev_reg};
					qev_next = ques_cond & ~ques_prev_reg;
				end
				`SSC_CMD_ERR_Q:
				begin
					if (err_empty)
						resp_next = `SSC_ERR_EMPTY;
					else
					begin
						resp_next = err_mem_reg[rp_reg[PW-1:0]]; // [R21]
						rp_next = rp_reg + 1'b1; // [R21]
					end
				end
				`SSC_CMD_VER_Q: resp_next = VERSION_WORD; // [R22]
				default: err_next = 1'b1;
			endcase
		end
		else if (wr && a == `SSC_OFF_ERRPUSH)
		begin
			// a full queue drops the newest entry
			if (!err_full)
			begin
				err_mem_next[wp_reg[PW-1:0]] = arg;
				wp_next = wp_reg + 1'b1;
			end
		end
		else if (wr && a == `SSC_OFF_EVSET)
		begin
			// event set wins over a same-cycle clear
			esr_next = esr_next | arg[7:0];
			irq_next = irq_next | arg[8];
		end
		else if (wr && a != `SSC_OFF_ARG)
			err_next = 1'b1;
		if (rd)
		begin
			case (a)
				`SSC_OFF_RESP: rdata_next = resp_reg;
				`SSC_OFF_STB: rdata_next = {24'h000000, stb}; // [R11]
				`SSC_OFF_IDN: rdata_next = IDN_WORD; // [R5]
				`SSC_OFF_FLAGS: rdata_next = {23'h000000, irq_reg, 1'b0, out_s2_reg, in_s2_reg};
				`SSC_OFF_CMD, `SSC_OFF_ARG, `SSC_OFF_ERRPUSH, `SSC_OFF_EVSET:
					rdata_next = 32'h00000000;
				default: err_next = 1'b1;
			endcase
		end
		srq_next = stb[`SSC_STB_RQS_BIT]; // [R9]
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ese_reg <= 8'h00;
			esr_reg <= 8'h00;
			sre_reg <= 8'h00;
			qen_reg <= 16'h0000;
			qev_reg <= 16'h0000;
			ques_prev_reg <= 16'h0000;
			open_reg <= 16'h0000;
			irq_reg <= 1'b0;
			resp_reg <= 32'h00000000;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			srq_reg <= 1'b0;
			wp_reg <= '0;
			rp_reg <= '0;
			for (int i = 0; i < ERR_DEPTH; i++)
				err_mem_reg[i] <= '0;
		end
		else
		begin
			ese_reg <= ese_next;
			esr_reg <= esr_next;
			sre_reg <= sre_next;
			qen_reg <= qen_next;
			qev_reg <= qev_next;
			ques_prev_reg <= ques_prev_next;
			open_reg <= open_next;
			irq_reg <= irq_next;
			resp_reg <= resp_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
			srq_reg <= srq_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			err_mem_reg <= err_mem_next;
		end
	end

	always_comb
	begin
		apb_rsp.pready = ready_reg;
		apb_rsp.pslverr = err_reg;
		apb_rsp.prdata = rdata_reg;
	end
	assign srq = srq_reg;
	assign irq_bit = irq_reg;
endmodule : ssc_status_core

/* File: ssc_chk_asserts.sv */
// checker for the status command block
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bus
	input wire ssc_pkg::ssc_apb_req_t apb_req,
	input wire ssc_pkg::ssc_apb_rsp_t apb_rsp,
	// pins
	input wire logic in_detect,
	input wire logic [5:0] out_detect,
	input wire logic srq,
	input wire logic irq_bit
);
	import ssc_pkg::*;
	logic tk;
	logic wc;
	assign tk = apb_req.psel && apb_req.penable && !apb_rsp.pready;
	assign wc = tk && apb_req.pwrite && apb_req.paddr == `SSC_OFF_CMD;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	property p_ans; tk |=> apb_rsp.pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
	property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_src; apb_rsp.pready |-> $past(tk); endproperty
	a_src: assert property (p_src) else $error("ready without access");
	property p_idle; !apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr; endproperty
	a_idle: assert property (p_idle) else $error("data outside ready");
	property p_rst; disable iff (1'b0) sys_rst |=> !srq && !irq_bit && !apb_rsp.pready; endproperty
	a_rst: assert property (p_rst) else $error("outputs after reset");
	property p_irq; tk && apb_req.pwrite && apb_req.paddr == `SSC_OFF_EVSET && apb_req.pwdata[8]
		|=> irq_bit; endproperty
	a_irq: assert property (p_irq) else $error("irq not set");
	property p_rstc; wc && apb_req.pwdata[4:0] == `SSC_CMD_RST |=> !irq_bit; endproperty
	a_rstc: assert property (p_rstc) else $error("irq not cleared");
	property p_sre; wc && apb_req.pwdata[4:0] == `SSC_CMD_SRE && apb_req.pwdata[15:8] == 8'h00
		|=> ##1 !srq; endproperty
	a_sre: assert property (p_sre) else $error("srq with zero mask");
	c_srq: cover property ($rose(srq));
	c_err: cover property (apb_rsp.pslverr);
	c_irq: cover property ($rose(irq_bit));
endmodule : ssc_chk
bind ssc_status_core ssc_chk ssc_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .in_detect(in_detect), .out_detect(out_detect), .srq(srq), .irq_bit(irq_bit));

/* File: ssc_detect_model.sv */
// detect circuit model driving the status block pins
`timescale 1ns/1ps
module ssc_detect_model (
	// fault controls
	input wire logic in_ok,
	input wire logic [5:0] fault,
	// detect pins, high is present
	output logic in_detect,
	output logic [5:0] out_detect
);
	assign in_detect = in_ok;
	// lost input starves every output
	assign out_detect = in_ok ? ~fault : 6'h00;
endmodule : ssc_detect_model

/* File: testbench.sv */
// testbench for the status command block
`timescale 1ns/1ps
`include "ssc_regs.svh"
module testbench;
	import ssc_pkg::*;
	localparam logic [31:0] IDN = 32'h00001D01; // arbitrary
	localparam logic [31:0] VER = 32'h00000042;
	typedef struct packed {logic [4:0] c; logic [23:0] a; logic [31:0] x; logic k;} ssc_row_t;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	ssc_apb_req_t req = '0;
	ssc_apb_rsp_t rsp;
	logic in_ok = 1'b1;
	logic [5:0] fault = 6'h00;
	logic in_detect;
	logic [5:0] out_detect;
	logic srq;
	logic irq_bit;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int n_compared = 0;
	ssc_row_t rows[22] = '{'{`SSC_CMD_ESE_Q, 0, 0, 1}, '{`SSC_CMD_ESE, 24'hA5, 0, 0},
		'{`SSC_CMD_ESE_Q, 0, 32'hA5, 1}, '{`SSC_CMD_SRE, 0, 0, 0}, '{`SSC_CMD_SRE, 24'h28, 0, 0},
		'{`SSC_CMD_SRE_Q, 0, 32'h28, 1}, '{`SSC_CMD_OPC, 0, 0, 0}, '{`SSC_CMD_WAI, 0, 0, 0},
		'{`SSC_CMD_OPC_Q, 0, 1, 1}, '{`SSC_CMD_TST_Q, 0, 0, 1}, '{`SSC_CMD_OPCOND_Q, 0, 0, 1},
		'{`SSC_CMD_OPEV_Q, 0, 0, 1}, '{`SSC_CMD_VER_Q, 0, VER, 1}, '{`SSC_CMD_IDN_Q, 0, IDN, 1},
		'{`SSC_CMD_OPEN, 24'h1234, 0, 0}, '{`SSC_CMD_OPEN_Q, 0, 32'h1234, 1},
		'{`SSC_CMD_QEN, 24'h600, 0, 0}, '{`SSC_CMD_QEN_Q, 0, 32'h600, 1},
		'{`SSC_CMD_PRESET, 0, 0, 0}, '{`SSC_CMD_OPEN_Q, 0, 0, 1}, '{`SSC_CMD_QEN_Q, 0, 0, 1},
		'{`SSC_CMD_QCOND_Q, 0, 0, 1}};
	ssc_status_core #(.IDN_WORD(IDN), .VERSION_WORD(VER)) ssc_status_core_inst (.mclk(mclk),
		.sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .in_detect(in_detect),
		.out_detect(out_detect), .srq(srq), .irq_bit(irq_bit));
	ssc_detect_model ssc_detect_model_inst (.in_ok(in_ok), .fault(fault), .in_detect(in_detect),
		.out_detect(out_detect));
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			failures++;
			$display("BAD t=%0t got %h want %h", $time, g, x);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (rsp.pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			failures++;
			final_report;
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task q(input logic [4:0] c, input logic [23:0] a, input logic [31:0] x, input logic k);
		apb(1'b1, `SSC_OFF_CMD, {a, 3'h0, c});
		if (k)
		begin
			apb(1'b0, `SSC_OFF_RESP, 32'h0);
			chk(rd, x);
		end
	endtask : q
	initial
	begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int j = 0; j < 22; j++)
			q(rows[j].c, rows[j].a, rows[j].x, rows[j].k);
		$display("table done");
		q(`SSC_CMD_QEN, 24'h600, 0, 0);
		fault <= 6'h28;
		for (int i = 0; i < 50 && srq !== 1'b1; i++)
			@(posedge mclk);
		chk({31'h0, srq}, 32'h1);
		q(`SSC_CMD_OUT_Q, 0, 32'h28, 1);
		q(`SSC_CMD_OUT_Q, 24'h4, 32'h1, 1);
		q(`SSC_CMD_OUT_Q, 24'h1, 32'h0, 1);
		q(`SSC_CMD_INP_Q, 0, 32'h0, 1);
		q(`SSC_CMD_QCOND_Q, 0, 32'h400, 1);
		apb(1'b0, `SSC_OFF_STB, 32'h0);
		chk(rd, 32'h48);
		in_ok <= 1'b0;
		repeat (3) @(posedge mclk);
		q(`SSC_CMD_INP_Q, 0, 32'h1, 1);
		q(`SSC_CMD_OUT_Q, 0, 32'h3F, 1);
		q(`SSC_CMD_QCOND_Q, 0, 32'h600, 1);
		in_ok <= 1'b1;
		fault <= 6'h00;
		repeat (3) @(posedge mclk);
		$display("detect done");
		q(`SSC_CMD_CLS, 0, 0, 0);
		apb(1'b0, `SSC_OFF_STB, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `SSC_OFF_EVSET, 32'h101);
		chk({31'h0, irq_bit}, 32'h1);
		apb(1'b0, `SSC_OFF_STB, 32'h0);
		chk(rd, 32'h60);
		q(`SSC_CMD_ESR_Q, 0, 32'h1, 1);
		q(`SSC_CMD_ESR_Q, 0, 32'h0, 1);
		q(`SSC_CMD_RST, 0, 0, 0);
		chk({31'h0, irq_bit}, 32'h0);
		$display("status done");
		apb(1'b1, `SSC_OFF_ERRPUSH, 32'h00710003);
		apb(1'b1, `SSC_OFF_ERRPUSH, 32'h00720004);
		q(`SSC_CMD_ERR_Q, 0, 32'h00710003, 1);
		q(`SSC_CMD_ERR_Q, 0, 32'h00720004, 1);
		apb(1'b1, `SSC_OFF_ERRPUSH, 32'h00730005);
		q(`SSC_CMD_CLS, 0, 0, 0);
		q(`SSC_CMD_ERR_Q, 0, 32'h0, 1);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("queue done");
		final_report;
	end
endmodule : testbench
